// ===== design/msrs_consts.vh
// Constants for the multi-source reset sequencer
`ifndef MSRS_CONSTS_VH
`define MSRS_CONSTS_VH

// Sequencer states
`define MSRS_ST_RUN 3'h0
`define MSRS_ST_COLD 3'h1
`define MSRS_ST_WARM 3'h2
`define MSRS_ST_SYS 3'h3
`define MSRS_ST_INIT 3'h4
`define MSRS_ST_PAUSE 3'h5
`define MSRS_ST_CPU 3'h6

// Reset type status layout, bit 2 and bits above 3 read zero
`define MSRS_STAT_W 4
`define MSRS_STAT_COLD 4'h1
`define MSRS_STAT_WARM 4'h2
`define MSRS_STAT_SYS 4'h8
`define MSRS_STAT_RST 4'h1

// Latched configuration: boot select on top of the option pins
`define MSRS_CFG_W 23
`define MSRS_BOOT_W 4
`define MSRS_DEVICE_STATUS_REG_W 27
`define MSRS_SYNC_W 29

// Timing: reference clock period in sys_clk cycles and pause length
`define MSRS_TMR_W 16
`define MSRS_REF_DIV 16'h0004
`define MSRS_PAUSE_REF_CYC 16'h000A
`define MSRS_LOCK_WAIT_CYC 16'h0200

`endif

// ===== design/msrs_sync.v
// Two-flop synchroniser for the reset and configuration pins
`default_nettype none
`include "msrs_consts.vh"

module msrs_sync (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Pin side and synchronised side
    input wire [`MSRS_SYNC_W-1:0] pin_in,
    output reg [`MSRS_SYNC_W-1:0] pin_sync
);

    reg [`MSRS_SYNC_W-1:0] meta_reg;

    // Clears to zero, so both reset pins read as asserted until sampled
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= {`MSRS_SYNC_W{1'b0}};
            pin_sync <= {`MSRS_SYNC_W{1'b0}};
        end
        else
        begin
            meta_reg <= pin_in;
            pin_sync <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ===== design/msrs_timer.v
// One-shot timer counting divided reference ticks
`default_nettype none
`include "msrs_consts.vh"

module msrs_timer (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Control
    input wire clear,
    input wire start,
    input wire [`MSRS_TMR_W-1:0] div_limit,
    input wire [`MSRS_TMR_W-1:0] target,
    // One-cycle pulse when the count is reached
    output reg done
);

    reg running_reg;
    reg [`MSRS_TMR_W-1:0] div_reg;
    reg [`MSRS_TMR_W-1:0] cnt_reg;
    wire tick;

    // Reference-rate enable pulse from the divider
    assign tick = running_reg && (div_reg >= div_limit - 16'h0001);

    // Divider and tick counter; clear wins over start
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            running_reg <= 1'b0;
            div_reg <= 16'h0000;
            cnt_reg <= 16'h0000;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (clear)
            begin
                running_reg <= 1'b0;
                div_reg <= 16'h0000;
                cnt_reg <= 16'h0000;
            end
            else if (start)
            begin
                running_reg <= 1'b1;
                div_reg <= 16'h0000;
                cnt_reg <= 16'h0000;
            end
            else if (running_reg)
            begin
                div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
                if (tick)
                begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg + 16'h0001 >= target)
                    begin
                        running_reg <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== design/msrs_reset_seq.v
// Chip reset sequencer: cold, warm, system and CPU-local resets
`default_nettype none
`include "msrs_consts.vh"

module msrs_reset_seq (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Reset pins from the board, active low
    input wire cold_reset_n,
    input wire warm_reset_n,
    // Configuration and boot select pins
    input wire [`MSRS_CFG_W-1:0] cfg_pins,
    input wire [`MSRS_BOOT_W-1:0] boot_select_pins,
    // Internal requests
    input wire max_reset_req,
    input wire sys_reset_req,
    input wire sys_reset_mask,
    input wire host_port_cpu_req,
    input wire pci_cpu_req,
    input wire pci_enabled,
    input wire init_done,
    // Status
    output reg reset_in_progress_n,
    output reg [`MSRS_STAT_W-1:0] reset_type,
    output reg [`MSRS_DEVICE_STATUS_REG_W-1:0] device_status_reg,
    output reg [`MSRS_BOOT_W-1:0] boot_select,
    // Reset distribution, active low
    output reg test_emu_reset_n,
    output reg core_reset_n,
    output reg cpu_reset_n,
    output reg mem_regs_reset_n,
    output reg mem_fsm_reset_n,
    output reg main_ctl_reset_n,
    output reg aux_ctl_reset_n,
    // PLL and clock control
    output reg main_pll_reset,
    output reg aux_pll_reset,
    output reg aux_clk_valid,
    output reg ctl_ref_clk_mode,
    output reg sysclk_default_div,
    output reg sysclk_run,
    // Pin group control
    output reg pins_all_hiz,
    output reg pins_reset_state,
    output reg pci_pins_hold,
    output reg pci_pins_hiz,
    output reg host_ready_out,
    output reg host_ready_oe
);

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`MSRS_STAT_W-1:0] stat_next;
    reg latch_cfg;
    reg pci_was_en_reg;
    wire pci_cpu_now;
    wire [`MSRS_SYNC_W-1:0] pins_s;
    wire cold_n_s;
    wire warm_n_s;
    wire [`MSRS_CFG_W-1:0] cfg_s;
    wire [`MSRS_BOOT_W-1:0] boot_s;
    wire warm_active;
    wire sys_go;
    wire cpu_any;
    wire cold_release;
    wire pause_start;
    wire lock_done;
    wire pause_done;
    wire n_cold;
    wire n_warm;
    wire n_sys;
    wire n_init;
    wire n_cpu;

    // Equality test used by every output decode
    function is_state;
        input [2:0] st;
        input [2:0] want;
        begin
            is_state = (st == want);
        end
    endfunction

    // All pins pass two flops; no logic reads the first stage
    msrs_sync u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin_in({boot_select_pins, cfg_pins, warm_reset_n, cold_reset_n}),
        .pin_sync(pins_s)
    );

    assign cold_n_s = pins_s[0];
    assign warm_n_s = pins_s[1];
    assign cfg_s = pins_s[`MSRS_CFG_W+1:2];
    assign boot_s = pins_s[`MSRS_SYNC_W-1:`MSRS_CFG_W+2];

    // Request qualification; maximum reset behaves as a warm one
    assign warm_active = !warm_n_s || max_reset_req;
    assign sys_go = sys_reset_req && !sys_reset_mask;
    assign cpu_any = host_port_cpu_req || pci_cpu_req;
    // Unregistered, so the PCI pins float in the same cycle the CPU reset starts
    assign pci_cpu_now = pci_cpu_req && !sys_go;
    assign cold_release = is_state(state_reg, `MSRS_ST_COLD) && cold_n_s;
    assign pause_start = is_state(state_next, `MSRS_ST_PAUSE)
        && !is_state(state_reg, `MSRS_ST_PAUSE);

    // both pins high
    // Cold preempts anything; warm preempts everything but cold
    always @*
    begin
        state_next = state_reg;
        stat_next = reset_type;
        latch_cfg = 1'b0;
        if (!cold_n_s)
        begin
            state_next = `MSRS_ST_COLD;
            stat_next = `MSRS_STAT_COLD;
        end
        else if (cold_release)
        begin
            latch_cfg = 1'b1;
            state_next = warm_active ? `MSRS_ST_WARM : `MSRS_ST_INIT;
        end
        else if (warm_active)
        begin
            if (!is_state(state_reg, `MSRS_ST_WARM))
            begin
                stat_next = `MSRS_STAT_WARM;
            end
            state_next = `MSRS_ST_WARM;
        end
        else if (is_state(state_reg, `MSRS_ST_WARM))
        begin
            latch_cfg = 1'b1;
            state_next = `MSRS_ST_INIT;
        end
        else
        begin
            case (state_reg)
                `MSRS_ST_RUN, `MSRS_ST_CPU:
                begin
                    if (sys_go)
                    begin
                        state_next = `MSRS_ST_SYS;
                        stat_next = `MSRS_STAT_SYS;
                    end
                    else if (cpu_any)
                    begin
                        state_next = `MSRS_ST_CPU;
                    end
                    else
                    begin
                        state_next = `MSRS_ST_RUN;
                    end
                end
                `MSRS_ST_SYS:
                begin
                    if (!sys_go)
                    begin
                        state_next = `MSRS_ST_INIT;
                    end
                end
                `MSRS_ST_INIT:
                begin
                    if (init_done && aux_clk_valid)
                    begin
                        state_next = `MSRS_ST_PAUSE;
                    end
                end
                `MSRS_ST_PAUSE:
                begin
                    if (pause_done)
                    begin
                        state_next = `MSRS_ST_RUN;
                    end
                end
                default:
                begin
                    state_next = `MSRS_ST_RUN;
                end
            endcase
        end
    end

    // Power-up lands in cold reset and records it
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= `MSRS_ST_COLD;
            reset_type <= `MSRS_STAT_RST;
        end
        else
        begin
            state_reg <= state_next;
            reset_type <= stat_next;
        end
    end

    // lock wait counter
    // Started as the aux PLL leaves reset, cleared while cold is low
    msrs_timer u_lock_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clear(!cold_n_s),
        .start(cold_release),
        .div_limit(16'h0001),
        .target(`MSRS_LOCK_WAIT_CYC),
        .done(lock_done)
    );

    // ten reference cycles
    // Pause counts reference ticks, not sys_clk cycles
    msrs_timer u_pause_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clear(!cold_n_s),
        .start(pause_start),
        .div_limit(`MSRS_REF_DIV),
        .target(`MSRS_PAUSE_REF_CYC),
        .done(pause_done)
    );

    // Decode of the state being entered, so outputs are all flops
    assign n_cold = is_state(state_next, `MSRS_ST_COLD);
    assign n_warm = is_state(state_next, `MSRS_ST_WARM);
    assign n_sys = is_state(state_next, `MSRS_ST_SYS);
    assign n_init = is_state(state_next, `MSRS_ST_INIT);
    assign n_cpu = is_state(state_next, `MSRS_ST_CPU);

    // Reset distribution and status pin
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reset_in_progress_n <= 1'b0;
            test_emu_reset_n <= 1'b0;
            core_reset_n <= 1'b0;
            cpu_reset_n <= 1'b0;
            mem_regs_reset_n <= 1'b0;
            mem_fsm_reset_n <= 1'b0;
            main_ctl_reset_n <= 1'b0;
            aux_ctl_reset_n <= 1'b0;
        end
        else
        begin
            reset_in_progress_n <= !(n_cold || n_warm || n_sys || n_init);
            test_emu_reset_n <= !n_cold;
            core_reset_n <= !(n_cold || n_warm || n_sys);
            cpu_reset_n <= !(n_cold || n_warm || n_sys || n_cpu);
            mem_regs_reset_n <= !(n_cold || n_warm);
            mem_fsm_reset_n <= !(n_cold || n_warm || n_sys);
            main_ctl_reset_n <= !(n_cold || n_warm);
            aux_ctl_reset_n <= !(n_cold || n_warm);
        end
    end

    // PLL and system clock control
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            main_pll_reset <= 1'b1;
            aux_pll_reset <= 1'b1;
            aux_clk_valid <= 1'b0;
            ctl_ref_clk_mode <= 1'b1;
            sysclk_default_div <= 1'b0;
            sysclk_run <= 1'b1;
        end
        else
        begin
            main_pll_reset <= n_cold || n_warm;
            aux_pll_reset <= n_cold;
            if (n_cold)
            begin
                aux_clk_valid <= 1'b0;
            end
            else if (lock_done)
            begin
                aux_clk_valid <= 1'b1;
            end
            ctl_ref_clk_mode <= n_cold || n_warm;
            sysclk_default_div <= latch_cfg;
            // pause after every init
            // Downstream gating stops at the end of the current clock cycle
            sysclk_run <= !is_state(state_next, `MSRS_ST_PAUSE);
        end
    end

    // Configuration capture; system reset never re-latches
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            device_status_reg <= {`MSRS_DEVICE_STATUS_REG_W{1'b0}};
            boot_select <= {`MSRS_BOOT_W{1'b0}};
        end
        else if (latch_cfg)
        begin
            device_status_reg <= {boot_s, cfg_s};
            boot_select <= boot_s;
        end
    end

    // PCI enable is frozen on warm reset entry so warm knows the old state
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pci_was_en_reg <= 1'b0;
        end
        else
        begin
            if (n_cold)
            begin
                pci_was_en_reg <= 1'b0;
            end
            else if (!n_warm && !is_state(state_reg, `MSRS_ST_WARM))
            begin
                pci_was_en_reg <= pci_enabled;
            end
        end
    end

    // Pin group control
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pins_all_hiz <= 1'b1;
            pins_reset_state <= 1'b0;
            pci_pins_hold <= 1'b0;
            pci_pins_hiz <= 1'b0;
            host_ready_out <= 1'b0;
            host_ready_oe <= 1'b0;
        end
        else
        begin
            pins_all_hiz <= n_cold;
            pins_reset_state <= n_warm;
            pci_pins_hold <= n_warm && pci_was_en_reg;
            pci_pins_hiz <= n_cpu && pci_cpu_now;
            host_ready_out <= n_cpu && pci_cpu_now;
            host_ready_oe <= n_cpu && pci_cpu_now;
        end
    end

endmodule
`default_nettype wire

// ===== tb/msrs_seq_asserts.sv
// Port-level assertions for the reset sequencer
`default_nettype none
`include "msrs_consts.vh"

module msrs_seq_asserts (
    // Clock and power-good reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Requests
    input wire logic cold_reset_n,
    input wire logic warm_reset_n,
    input wire logic max_reset_req,
    input wire logic sys_reset_req,
    input wire logic sys_reset_mask,
    input wire logic host_port_cpu_req,
    input wire logic pci_cpu_req,
    // Status and reset outputs
    input wire logic reset_in_progress_n,
    input wire logic [`MSRS_STAT_W-1:0] reset_type,
    input wire logic [`MSRS_DEVICE_STATUS_REG_W-1:0] device_status_reg,
    input wire logic test_emu_reset_n,
    input wire logic core_reset_n,
    input wire logic cpu_reset_n,
    input wire logic mem_regs_reset_n,
    input wire logic mem_fsm_reset_n,
    input wire logic main_ctl_reset_n,
    input wire logic aux_ctl_reset_n,
    // Clock control and pin groups
    input wire logic main_pll_reset,
    input wire logic aux_pll_reset,
    input wire logic aux_clk_valid,
    input wire logic ctl_ref_clk_mode,
    input wire logic sysclk_default_div,
    input wire logic sysclk_run,
    input wire logic pins_all_hiz,
    input wire logic pins_reset_state,
    input wire logic pci_pins_hiz,
    input wire logic host_ready_out,
    input wire logic host_ready_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] low_cnt;
    logic run_idle;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // Running with no pin or max reset pending, so a new request is taken
    assign run_idle = reset_in_progress_n && sysclk_run && cold_reset_n && warm_reset_n
        && !max_reset_req;

    // Pause length; saturates so a stuck clock cannot wrap back into range
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            low_cnt <= 8'h00;
        else if (sysclk_run)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF)
            low_cnt <= low_cnt + 8'h01;
    end

    sequence pause_end_s;
        $rose(sysclk_run);
    endsequence
    sequence sys_go_s;
        sys_reset_req && !sys_reset_mask && run_idle;
    endsequence
    sequence cpu_go_s;
        (host_port_cpu_req || pci_cpu_req) && !sys_reset_req && run_idle;
    endsequence

    cold_scope_a: assert property (
        !test_emu_reset_n |-> !core_reset_n && !cpu_reset_n && !mem_regs_reset_n)
        else $error("cold reset left a block running");
    cold_hiz_a: assert property (
        !test_emu_reset_n |-> pins_all_hiz && reset_type == `MSRS_STAT_COLD)
        else $error("pins driven or type wrong in cold reset");
    cold_pll_a: assert property (
        pins_all_hiz |-> main_pll_reset && aux_pll_reset && !aux_clk_valid && ctl_ref_clk_mode)
        else $error("PLL control wrong in cold reset");
    rip_low_a: assert property (
        !core_reset_n |-> !reset_in_progress_n)
        else $error("reset in progress high during reset");
    warm_spare_a: assert property (
        pins_reset_state |-> test_emu_reset_n && !aux_pll_reset && !aux_ctl_reset_n
        && !main_ctl_reset_n && main_pll_reset)
        else $error("warm reset scope wrong");
    div_pulse_a: assert property (
        sysclk_default_div |-> !reset_in_progress_n ##1 !sysclk_default_div)
        else $error("default divider pulse wrong");
    pause_len_a: assert property (
        pause_end_s |-> low_cnt inside {40, 41})
        else $error("clock pause length wrong");
    sys_scope_a: assert property (
        sys_go_s |=> !reset_in_progress_n && reset_type == `MSRS_STAT_SYS && !mem_fsm_reset_n
        && mem_regs_reset_n && !main_pll_reset && main_ctl_reset_n)
        else $error("system reset scope wrong");
    sys_cfg_a: assert property (
        !core_reset_n && test_emu_reset_n && !pins_reset_state |=> $stable(device_status_reg))
        else $error("status changed by system reset");
    cpu_only_a: assert property (
        cpu_go_s |=> !cpu_reset_n && core_reset_n && reset_in_progress_n)
        else $error("CPU reset scope wrong");
    pci_pins_a: assert property (
        pci_cpu_req && !sys_reset_req && run_idle |=> pci_pins_hiz && host_ready_out
        && host_ready_oe)
        else $error("PCI pins wrong in CPU reset");
endmodule

bind msrs_reset_seq msrs_seq_asserts msrs_seq_asserts_i (.sys_clk, .resetn, .cold_reset_n,
    .warm_reset_n, .max_reset_req, .sys_reset_req, .sys_reset_mask, .host_port_cpu_req,
    .pci_cpu_req, .reset_in_progress_n, .reset_type, .device_status_reg, .test_emu_reset_n,
    .core_reset_n, .cpu_reset_n, .mem_regs_reset_n, .mem_fsm_reset_n, .main_ctl_reset_n,
    .aux_ctl_reset_n, .main_pll_reset, .aux_pll_reset, .aux_clk_valid, .ctl_ref_clk_mode,
    .sysclk_default_div, .sysclk_run, .pins_all_hiz, .pins_reset_state, .pci_pins_hiz,
    .host_ready_out, .host_ready_oe);
`default_nettype wire

// ===== tb/msrs_board_model.sv
// Board supervisor and emulator driving the reset requests
`default_nettype none

module msrs_board_model #(
    parameter int REF_DIV = 4,
    parameter int SYS_HOLD = 30
) (
    // Clock
    input wire logic sys_clk,
    // Commands from the bench
    input wire logic warm_go,
    input wire logic sys_go,
    input wire logic mask_go,
    // Reset sources
    output logic cold_reset_n,
    output logic warm_reset_n,
    output logic sys_reset_req,
    output logic sys_reset_mask
);
    timeunit 1ns;
    timeprecision 1ps;

    // One request at a time, so the two pins never move together
    initial
    begin
        cold_reset_n = 1'b0;
        warm_reset_n = 1'b1;
        sys_reset_req = 1'b0;
        sys_reset_mask = 1'b0;
        repeat (256 * REF_DIV) @(posedge sys_clk);
        cold_reset_n <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (warm_go)
            begin
                warm_reset_n <= 1'b0;
                repeat (24 * REF_DIV) @(posedge sys_clk);
                warm_reset_n <= 1'b1;
            end
            else if (sys_go)
            begin
                sys_reset_mask <= mask_go;
                sys_reset_req <= 1'b1;
                repeat (SYS_HOLD) @(posedge sys_clk);
                sys_reset_req <= 1'b0;
                sys_reset_mask <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/msrs_reset_seq_tb.sv
// Self-checking bench for the reset sequencer
`default_nettype none
`include "msrs_consts.vh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0d ns: got %h want %h", $time, got, exp); end end
`define WAITC(c) for (int w = 0; w < 3000 && (c) !== 1'b1; w++) tick(1); \
    if ((c) !== 1'b1) begin n_errors++; \
    $display("unexpected at %0d ns: wait timed out", $time); end

module msrs_reset_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    int n_errors = 0;
    int n_tests = 0;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic warm_go = 1'b0;
    logic sys_go = 1'b0;
    logic mask_go = 1'b0;
    logic [`MSRS_CFG_W-1:0] cfg_pins = 23'h2A5A5A;
    logic [`MSRS_BOOT_W-1:0] boot_select_pins = 4'hC;
    logic max_reset_req = 1'b0;
    logic host_port_cpu_req = 1'b0;
    logic pci_cpu_req = 1'b0;
    logic pci_enabled = 1'b0;
    logic init_done = 1'b0;
    logic cold_reset_n, warm_reset_n, sys_reset_req, sys_reset_mask;
    logic reset_in_progress_n, test_emu_reset_n, core_reset_n, cpu_reset_n;
    logic mem_regs_reset_n, mem_fsm_reset_n, main_pll_reset, aux_pll_reset;
    logic aux_clk_valid, sysclk_default_div, sysclk_run, pins_all_hiz;
    logic pins_reset_state, pci_pins_hold, pci_pins_hiz, host_ready_out;
    logic [`MSRS_STAT_W-1:0] reset_type;
    logic [`MSRS_DEVICE_STATUS_REG_W-1:0] device_status_reg;
    logic [`MSRS_BOOT_W-1:0] boot_select;

    msrs_board_model msrs_board_model_i (.sys_clk, .warm_go, .sys_go, .mask_go, .cold_reset_n,
        .warm_reset_n, .sys_reset_req, .sys_reset_mask);
    msrs_reset_seq msrs_reset_seq_i (.sys_clk, .resetn, .cold_reset_n, .warm_reset_n, .cfg_pins,
        .boot_select_pins, .max_reset_req, .sys_reset_req, .sys_reset_mask, .host_port_cpu_req,
        .pci_cpu_req, .pci_enabled, .init_done, .reset_in_progress_n, .reset_type,
        .device_status_reg, .boot_select, .test_emu_reset_n, .core_reset_n, .cpu_reset_n,
        .mem_regs_reset_n, .mem_fsm_reset_n, .main_ctl_reset_n(), .aux_ctl_reset_n(),
        .main_pll_reset, .aux_pll_reset, .aux_clk_valid, .ctl_ref_clk_mode(),
        .sysclk_default_div, .sysclk_run, .pins_all_hiz, .pins_reset_state, .pci_pins_hold,
        .pci_pins_hiz, .host_ready_out, .host_ready_oe());

    // 100 MHz system clock
    initial
    begin
        forever
            #5 sys_clk = ~sys_clk;
    end

    // Sample 1 ns after the edge so flop updates have landed
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    // Init done is already high; measure the clock pause after status rises
    task automatic finish_init;
        int k;
        k = 0;
        `WAITC(reset_in_progress_n)
        `CHK(sysclk_run, 1'b0)
        while (sysclk_run !== 1'b1 && k < 60)
        begin
            tick(1);
            k++;
        end
        `CHK(k inside {40, 41}, 1'b1)
    endtask

    task automatic t_cold;
        tick(2);
        `CHK({pins_all_hiz, test_emu_reset_n, core_reset_n}, 3'b100)
        `CHK({main_pll_reset, aux_pll_reset, aux_clk_valid}, 3'b110)
        `CHK({reset_in_progress_n, reset_type}, 5'h01)
        `WAITC(sysclk_default_div)
        `CHK(device_status_reg, {4'hC, 23'h2A5A5A})
        `CHK({boot_select, aux_pll_reset, pins_all_hiz}, 6'h30)
        `WAITC(aux_clk_valid)
        `CHK({aux_clk_valid, reset_in_progress_n}, 2'b10)
        @(posedge sys_clk) init_done <= 1'b1;
        finish_init();
        $display("cold reset test done");
    endtask

    // Warm reset with PCI enabled and new configuration pins
    task automatic t_warm;
        @(posedge sys_clk);
        pci_enabled <= 1'b1;
        cfg_pins <= 23'h15A5A5;
        boot_select_pins <= 4'h3;
        warm_go <= 1'b1;
        @(posedge sys_clk) warm_go <= 1'b0;
        `WAITC(pins_reset_state)
        `CHK({reset_type, pci_pins_hold}, 5'h05)
        `CHK({test_emu_reset_n, aux_pll_reset, aux_clk_valid}, 3'b101)
        `CHK({core_reset_n, main_pll_reset, reset_in_progress_n}, 3'b010)
        `WAITC(sysclk_default_div)
        `CHK(device_status_reg, {4'h3, 23'h15A5A5})
        finish_init();
        $display("warm reset test done");
    endtask

    // Masked request first, then a real one; pins change but must not latch
    task automatic t_sys;
        @(posedge sys_clk);
        cfg_pins <= 23'h000000;
        boot_select_pins <= 4'h0;
        mask_go <= 1'b1;
        sys_go <= 1'b1;
        @(posedge sys_clk) sys_go <= 1'b0;
        tick(20);
        `CHK({reset_in_progress_n, reset_type}, 5'h12)
        tick(15);
        @(posedge sys_clk);
        mask_go <= 1'b0;
        sys_go <= 1'b1;
        @(posedge sys_clk) sys_go <= 1'b0;
        `WAITC(~reset_in_progress_n)
        `CHK(reset_type, `MSRS_STAT_SYS)
        `CHK({mem_regs_reset_n, mem_fsm_reset_n, test_emu_reset_n}, 3'b101)
        `CHK({main_pll_reset, aux_clk_valid, core_reset_n}, 3'b010)
        finish_init();
        `CHK({boot_select, device_status_reg}, {4'h3, 4'h3, 23'h15A5A5})
        $display("system reset test done");
    endtask

    // CPU-local reset from the host port, then from PCI
    task automatic t_cpu;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            host_port_cpu_req <= (i == 0);
            pci_cpu_req <= (i == 1);
            tick(3);
            `CHK({cpu_reset_n, core_reset_n, reset_in_progress_n}, 3'b011)
            `CHK({pci_pins_hiz, host_ready_out}, {2{i == 1}})
            @(posedge sys_clk);
            host_port_cpu_req <= 1'b0;
            pci_cpu_req <= 1'b0;
            tick(3);
            `CHK(cpu_reset_n, 1'b1)
        end
        $display("CPU reset test done");
    endtask

    // Max and system requests in the same cycle: only the higher one runs
    task automatic t_prio;
        @(posedge sys_clk) sys_go <= 1'b1;
        @(posedge sys_clk);
        sys_go <= 1'b0;
        max_reset_req <= 1'b1;
        tick(3);
        `CHK({reset_type, pins_reset_state}, 5'h05)
        tick(40);
        @(posedge sys_clk) max_reset_req <= 1'b0;
        finish_init();
        $display("priority test done");
    endtask

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence after a 20-cycle power-good reset
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_cold();
        t_warm();
        t_sys();
        t_cpu();
        t_prio();
        conclude();
    end

    // Watchdog: the whole run needs about 2000 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        $display("unexpected at %0d ns: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
